/* File: dv/stc_strap_model.sv */
`include "stc_params.svh"

// Board side of the strap pins: pull resistors or fitted jumpers
module stc_strap_model
  import stc_pkg::*;
(
  input  wire logic  use_jumpers,
  input  stc_straps_t jumper_val,
  output stc_straps_t strap_pins
);
  timeunit 1ns;
  timeprecision 1ps;

  // Internal pull levels win while no jumper is fitted
  localparam stc_straps_t PULLS = {`STC_DEF_ADDR, `STC_DEF_MODE,
    `STC_DEF_ISOLATE, `STC_DEF_SPEED, `STC_DEF_DUPLEX, `STC_DEF_AUTONEG,
    `STC_DEF_BCAST_OFF, `STC_DEF_WAKE_EN, `STC_DEF_NAND_N};

  // Levels follow the jumpers at once, whenever the bench refits them
  assign strap_pins = use_jumpers ? jumper_val : PULLS;
endmodule

/* File: dv/stc_top_props.sv */
// Checker beside the strap capture top, ports only
module stc_top_props
  import stc_pkg::*;
#(
  parameter bit HAS_SPEED = 1'b1,  // Speed strap present
  parameter bit HAS_WAKE  = 1'b1   // Wake strap present
) (
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [11:0]  paddr,
  input wire logic [31:0]  pwdata,
  input wire logic [3:0]   pstrb,
  input wire logic [31:0]  prdata,
  input wire logic         pready,
  input wire logic         pslverr,
  input stc_straps_t       strap_pins,
  input wire logic [4:0]   mgmt_query_addr,
  input wire logic         mgmt_query_valid,
  input wire logic         mgmt_addr_hit,
  input wire logic         wake_event_req,
  input wire logic         wake_event_output_n,
  input wire logic [4:0]   station_addr,
  input stc_if_mode_t      if_mode,
  input wire logic         isolate_en,
  input wire logic         speed_100,
  input wire logic         duplex_half,
  input wire logic         autoneg_en,
  input wire logic         nand_tree_en,
  input wire logic         straps_valid
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0]  cnt_reg;   // Edges since release, saturates at 3
  stc_straps_t samp_reg;  // Pin levels at the first edge after release

  // Own copy of the sample so outputs are tied to the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg  <= 2'h0;
      samp_reg <= '0;
    end else begin
      if (cnt_reg != 2'h3) begin
        cnt_reg <= cnt_reg + 2'h1;
      end
      if (cnt_reg == 2'h0) begin
        samp_reg <= strap_pins;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_valid_time;
    cnt_reg == 2'h3 |-> straps_valid;
  endproperty
  a_valid_time: assert property (p_valid_time)
    else $error("straps not valid three edges after release");

  property p_addr;
    straps_valid |-> station_addr == {2'h0, samp_reg.station_addr};
  endproperty
  a_addr: assert property (p_addr)
    else $error("station address differs from sampled straps");

  property p_mode;
    straps_valid |-> if_mode == ((samp_reg.mode == 3'h1) ? STC_IF_RMII :
      (samp_reg.mode == 3'h5) ? STC_IF_B2B : STC_IF_RESV);
  endproperty
  a_mode: assert property (p_mode)
    else $error("interface mode differs from sampled straps");

  property p_nand;
    straps_valid |-> nand_tree_en == !samp_reg.nand_n;
  endproperty
  a_nand: assert property (p_nand)
    else $error("test mode differs from sampled strap");

  property p_ctl_load;
    $rose(straps_valid) |-> {isolate_en, speed_100, duplex_half, autoneg_en}
      == {samp_reg.isolate, HAS_SPEED ? samp_reg.speed : 1'b1,
          samp_reg.duplex, samp_reg.autoneg};
  endproperty
  a_ctl_load: assert property (p_ctl_load)
    else $error("control bits not loaded from straps");

  property p_hold;
    straps_valid && $past(straps_valid) |->
      $stable(station_addr) && $stable(if_mode) && $stable(nand_tree_en);
  endproperty
  a_hold: assert property (p_hold)
    else $error("captured strap outputs moved without reset");

  property p_hit;
    mgmt_query_valid && straps_valid |=> mgmt_addr_hit ==
      (($past(mgmt_query_addr) == station_addr &&
        (station_addr != 5'h0 || samp_reg.bcast_off)) ||
       ($past(mgmt_query_addr) == 5'h0 && !samp_reg.bcast_off));
  endproperty
  a_hit: assert property (p_hit)
    else $error("address match wrong for query");

  property p_wake;
    $past(straps_valid) |-> wake_event_output_n ==
      !(HAS_WAKE && samp_reg.wake_en && $past(wake_event_req));
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake output does not follow strap and request");
endmodule

bind stc_top stc_top_props #(.HAS_SPEED(HAS_SPEED), .HAS_WAKE(HAS_WAKE))
  stc_top_props_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .strap_pins(strap_pins), .mgmt_query_addr(mgmt_query_addr),
  .mgmt_query_valid(mgmt_query_valid), .mgmt_addr_hit(mgmt_addr_hit),
  .wake_event_req(wake_event_req),
  .wake_event_output_n(wake_event_output_n), .station_addr(station_addr),
  .if_mode(if_mode), .isolate_en(isolate_en), .speed_100(speed_100),
  .duplex_half(duplex_half), .autoneg_en(autoneg_en),
  .nand_tree_en(nand_tree_en), .straps_valid(straps_valid));

/* File: dv/strap_capture_at_reset_test.sv */
// Strap capture bench: resets with various jumpers, APB reads
module strap_capture_at_reset_test
  import stc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic         pclk, presetn, psel, penable, pwrite, pslverr, pready;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd_data;
  logic [3:0]   pstrb;
  logic [4:0]   q_addr, station_addr;
  logic         q_valid, hit, wake_req, wake_n, rd_err, use_jumpers;
  logic         isolate_en, speed_100, duplex_half, autoneg_en;
  logic         nand_tree_en, straps_valid;
  stc_if_mode_t if_mode;
  stc_straps_t  jumper_val, strap_pins;
  int           n_errors, samples_checked;

  // Free-running 40 MHz clock
  always #12.5 pclk = ~pclk;

  stc_strap_model stc_strap_model_i (.use_jumpers(use_jumpers),
    .jumper_val(jumper_val), .strap_pins(strap_pins));

  stc_top #(.HAS_SPEED(1'b1), .HAS_WAKE(1'b1)) stc_top_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .strap_pins(strap_pins),
    .mgmt_query_addr(q_addr), .mgmt_query_valid(q_valid),
    .mgmt_addr_hit(hit), .wake_event_req(wake_req),
    .wake_event_output_n(wake_n), .station_addr(station_addr),
    .if_mode(if_mode), .isolate_en(isolate_en), .speed_100(speed_100),
    .duplex_half(duplex_half), .autoneg_en(autoneg_en),
    .nand_tree_en(nand_tree_en), .straps_valid(straps_valid));

  // One compare, counted
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task complete_run;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Reset pulse; straps must already be settled
  task do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    @(negedge pclk);
  endtask

  // APB transfer; pready, data and error taken at the same rising edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50) begin
      n_errors++;
    end
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd_data);
    chk("pslverr", 1'b0, rd_err);
  endtask

  // Single query, hit looked at one cycle later
  task query(input logic [4:0] a, input logic e);
    @(posedge pclk);
    q_addr  <= a;
    q_valid <= 1'b1;
    @(posedge pclk);
    q_valid <= 1'b0;
    @(negedge pclk);
    chk("mgmt_addr_hit", e, hit);
  endtask

  task chk_outs(input logic [4:0] a, input logic [1:0] m,
                input logic [3:0] ctl, input logic t);
    chk("station_addr", a, station_addr);
    chk("if_mode", m, if_mode);
    chk("iso_spd_dup_an", ctl,
        {isolate_en, speed_100, duplex_half, autoneg_en});
    chk("nand_tree_en", t, nand_tree_en);
    chk("straps_valid", 1'b1, straps_valid);
  endtask

  // Hang guard, far beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    complete_run;
  end

  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0; pstrb = 4'hF;
    q_addr = 5'h00; q_valid = 1'b0; wake_req = 1'b0; use_jumpers = 1'b0;
    jumper_val = '0; n_errors = 0; samples_checked = 0;
    do_reset;
    // Pull defaults
    chk_outs(5'h01, 2'h0, 4'h7, 1'b0);
    rd_chk("basic", 12'h000, 32'h0000_3100);
    rd_chk("advert", 12'h004, 32'h0000_01E1);
    rd_chk("strap_stat", 12'h008, 32'h0000_1421);
    query(5'h01, 1'b1);
    query(5'h00, 1'b1);
    query(5'h02, 1'b0);
    @(posedge pclk);
    wake_req <= 1'b1;
    repeat (2) @(negedge pclk);
    chk("wake_n", 1'b1, wake_n);
    // Writes: basic mask, read-only place; read of unmapped place
    apb(1'b1, 12'h000, 32'hFFFF_FFFF);
    rd_chk("basic wr", 12'h000, 32'h0000_3500);
    apb(1'b1, 12'h004, 32'h0000_0000);
    rd_chk("advert ro", 12'h004, 32'h0000_01E1);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk("unmapped err", 1'b1, rd_err);
    // Jumpers fitted: nothing moves until reset
    @(posedge pclk);
    jumper_val  <= {3'h0, 3'h5, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    use_jumpers <= 1'b1;
    repeat (4) @(negedge pclk);
    chk_outs(5'h01, 2'h0, 4'hF, 1'b0);
    do_reset;
    chk_outs(5'h00, 2'h1, 4'h8, 1'b1);
    rd_chk("advert 10", 12'h004, 32'h0000_0061);
    query(5'h00, 1'b1);
    chk("wake_n on", 1'b0, wake_n);
    @(posedge pclk);
    wake_req <= 1'b0;
    jumper_val.station_addr <= 3'h7;
    repeat (2) @(negedge pclk);
    chk("wake_n off", 1'b1, wake_n);
    chk("station_addr held", 5'h00, station_addr);
    // Every mode code, address alongside, broadcast on
    for (int c = 0; c < 8; c++) begin
      @(posedge pclk);
      jumper_val.mode         <= c[2:0];
      jumper_val.station_addr <= c[2:0];
      jumper_val.bcast_off    <= 1'b0;
      do_reset;
      chk("mode", (c == 1) ? 2'h0 : (c == 5) ? 2'h1 : 2'h2, if_mode);
      chk("addr", {2'h0, c[2:0]}, station_addr);
      query(5'h00, 1'b1);
    end
    // Zero made unique while own address is seven: zero is not ours
    @(posedge pclk);
    jumper_val.bcast_off <= 1'b1;
    do_reset;
    query(5'h00, 1'b0);
    query(5'h07, 1'b1);
    complete_run;
  end
endmodule

/* File: hw/stc_addr_match.sv */
// Management address compare, one cycle of latency
module stc_addr_match (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [4:0] own_addr,
  input  wire logic       bcast_off,
  input  wire logic       enable,
  input  wire logic [4:0] query_addr,
  input  wire logic       query_valid,
  output logic            hit
);

  typedef struct packed {
    logic hit;
  } stc_match_reg_t;

  stc_match_reg_t cur_reg;   // Registered state
  stc_match_reg_t cur_next;  // Next state
  logic           own_hit;   // Query equals own address
  logic           bc_hit;    // Query is the broadcast address

  // Zero is ours only when made unique, else it is broadcast
  always_comb begin
    cur_next = cur_reg;
    own_hit  = (query_addr == own_addr) &&
               ((own_addr != 5'h00) || bcast_off);
    bc_hit   = (query_addr == 5'h00) && !bcast_off;
    cur_next.hit = enable && query_valid && (own_hit || bc_hit);
  end

  // Hit flag register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_reg.hit <= 1'b0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign hit = cur_reg.hit;

endmodule

/* File: hw/stc_capture.sv */
`include "stc_params.svh"

// Takes the strap levels once after reset release
module stc_capture
  import stc_pkg::*;
(
  input  wire logic  pclk,
  input  wire logic  presetn,
  input  stc_straps_t strap_pins,
  output stc_straps_t strap_q,
  output logic       strap_valid
);

  stc_cap_reg_t cur_reg;     // Registered state
  stc_cap_reg_t cur_next;    // Next state

  // Sample on the first edge after release, then freeze
  always_comb begin
    cur_next = cur_reg;
    case (cur_reg.state)
      STC_CAP_WAIT: begin
        cur_next.straps = strap_pins;
        cur_next.state  = STC_CAP_DONE;
      end
      STC_CAP_DONE: begin
        cur_next = cur_reg;
      end
      default: begin
        cur_next.state = STC_CAP_WAIT;
      end
    endcase
  end

  // Reset leaves the pull levels in place until the real sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_reg.state               <= STC_CAP_WAIT;
      cur_reg.straps.station_addr <= `STC_DEF_ADDR;
      cur_reg.straps.mode         <= `STC_DEF_MODE;
      cur_reg.straps.isolate      <= `STC_DEF_ISOLATE;
      cur_reg.straps.speed        <= `STC_DEF_SPEED;
      cur_reg.straps.duplex       <= `STC_DEF_DUPLEX;
      cur_reg.straps.autoneg      <= `STC_DEF_AUTONEG;
      cur_reg.straps.bcast_off    <= `STC_DEF_BCAST_OFF;
      cur_reg.straps.wake_en      <= `STC_DEF_WAKE_EN;
      cur_reg.straps.nand_n       <= `STC_DEF_NAND_N;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign strap_q     = cur_reg.straps;
  assign strap_valid = (cur_reg.state == STC_CAP_DONE);

endmodule

/* File: hw/stc_params.svh */
`ifndef STC_PARAMS_SVH
`define STC_PARAMS_SVH

// Register byte offsets on the APB slave
`define STC_BASIC_CTRL_OFF   12'h000
`define STC_ADVERT_OFF       12'h004
`define STC_STRAP_STAT_OFF   12'h008

// Basic control register bit positions
`define STC_BIT_SPEED        13
`define STC_BIT_AUTONEG      12
`define STC_BIT_ISOLATE      10
`define STC_BIT_DUPLEX       8

// Basic control writable bits
`define STC_BASIC_WMASK      16'h3500

// Advertisement fields
`define STC_ADV_100_MASK     16'h0180
`define STC_ADV_10_MASK      16'h0060
`define STC_ADV_SELECTOR     16'h0001

// Strap status field positions
`define STC_ST_ADDR_LSB      0
`define STC_ST_MODE_LSB      5
`define STC_ST_BCAST_BIT     8
`define STC_ST_WAKE_BIT      9
`define STC_ST_NAND_BIT      10
`define STC_ST_RESV_BIT      11
`define STC_ST_VALID_BIT     12

// Interface mode codes
`define STC_MODE_RMII        3'h1
`define STC_MODE_B2B         3'h5

// Strap levels that the internal pulls give
`define STC_DEF_ADDR         3'h1
`define STC_DEF_MODE         3'h1
`define STC_DEF_ISOLATE      1'h0
`define STC_DEF_SPEED        1'h1
`define STC_DEF_DUPLEX       1'h1
`define STC_DEF_AUTONEG      1'h1
`define STC_DEF_BCAST_OFF    1'h0
`define STC_DEF_WAKE_EN      1'h0
`define STC_DEF_NAND_N       1'h1

`endif

/* File: hw/stc_pkg.sv */
`include "stc_params.svh"

package stc_pkg;

  // Strap pin levels, one field per strap; address and mode fields are three pins wide
  typedef struct packed {
    logic [2:0] station_addr;   // Address straps, bit0 lowest
    logic [2:0] mode;           // Interface-mode straps
    logic       isolate;        // High enables isolation
    logic       speed;          // High is 100 Mb/s
    logic       duplex;         // High is half duplex
    logic       autoneg;        // High enables auto-negotiation
    logic       bcast_off;      // High makes address zero unique
    logic       wake_en;        // High enables wake output
    logic       nand_n;         // Low enables gate-chain test
  } stc_straps_t;

  // Decoded interface mode
  typedef enum logic [1:0] {
    STC_IF_RMII = 2'b00,
    STC_IF_B2B  = 2'b01,
    STC_IF_RESV = 2'b10
  } stc_if_mode_t;

  // Capture sequencer
  typedef enum logic [0:0] {
    STC_CAP_WAIT = 1'b0,
    STC_CAP_DONE = 1'b1
  } stc_cap_state_t;

  // Capture module state
  typedef struct packed {
    stc_cap_state_t state;
    stc_straps_t    straps;
  } stc_cap_reg_t;

  // Top module state
  typedef struct packed {
    logic         loaded;       // Control image taken from straps
    logic [15:0]  basic;        // Basic control image
    logic [15:0]  advert;       // Advertisement image
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
    logic [4:0]   station_addr;
    stc_if_mode_t if_mode;
    logic         isolate_en;
    logic         speed_100;
    logic         duplex_half;
    logic         autoneg_en;
    logic         wake_n;
    logic         nand_tree_en;
    logic         straps_valid;
  } stc_top_reg_t;

  // Mode code to mode kind
  function automatic stc_if_mode_t stc_mode_decode(input logic [2:0] code);
    stc_if_mode_t m;
    m = STC_IF_RESV;
    if (code == `STC_MODE_RMII) begin
      m = STC_IF_RMII;
    end else if (code == `STC_MODE_B2B) begin
      m = STC_IF_B2B;
    end
    return m;
  endfunction

  // Offset decode for the APB slave
  function automatic logic stc_addr_known(input logic [11:0] a);
    return (a == `STC_BASIC_CTRL_OFF) || (a == `STC_ADVERT_OFF) ||
           (a == `STC_STRAP_STAT_OFF);
  endfunction

endpackage

/* File: hw/stc_top.sv */
// Contract
// - Capture three address straps, values 0..7
// - Address defaults to 00001 from pulls
// - Address upper two bits forced zero
// - Address zero unique only if broadcast-disable
// - Broadcast-disable low makes zero broadcast
// - Latch mode straps; 001, 101, else reserved
// - Isolate strap into control bit 10
// - Speed strap into bit 13, advertisement
// - Duplex strap into control bit 8
// - Auto-negotiation strap into control bit 12
// - Wake strap enables wake event output
// - Test strap low enables gate-chain mode
// - Undriven straps take internal pull values
// - New strap levels need fresh reset
//
// The APB slave port and the address map were left to the implementer.
`include "stc_params.svh"

module stc_top
  import stc_pkg::*;
#(
  parameter bit HAS_SPEED = 1'b1,  // Speed strap present
  parameter bit HAS_WAKE  = 1'b1   // Wake support present
) (
  input  wire logic   pclk,
  input  wire logic   presetn,
  input  wire logic   psel,
  input  wire logic   penable,
  input  wire logic   pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  input  stc_straps_t strap_pins,
  input  wire logic [4:0]  mgmt_query_addr,
  input  wire logic        mgmt_query_valid,
  output logic        mgmt_addr_hit,
  input  wire logic        wake_event_req,
  output logic        wake_event_output_n,
  output logic [4:0]  station_addr,
  output stc_if_mode_t if_mode,
  output logic        isolate_en,
  output logic        speed_100,
  output logic        duplex_half,
  output logic        autoneg_en,
  output logic        nand_tree_en,
  output logic        straps_valid
);

  stc_top_reg_t cur_reg;        // All state of the top
  stc_top_reg_t cur_next;       // Next value of the state
  stc_straps_t  strap_q;        // Frozen strap levels
  logic         strap_done;     // Strap sample taken
  logic [4:0]   addr_full;      // Five-bit station address
  logic         speed_lvl;      // Speed strap after option
  logic         wake_lvl;       // Wake strap after option
  logic         setup_ph;       // APB setup cycle
  logic         access_done;    // APB access completes here
  logic         wr_basic;       // Write to basic control
  logic [15:0]  wr_half;        // Masked write data
  logic [31:0]  rd_word;        // Read mux result
  logic [15:0]  strap_basic;    // Control image from straps
  logic [15:0]  strap_adv;      // Advertisement from straps
  logic [31:0]  status_word;    // Strap status view

  // Strap sampler, freezes levels after first post-reset edge
  stc_capture u_capture (
    .pclk        (pclk),
    .presetn     (presetn),
    .strap_pins  (strap_pins),
    .strap_q     (strap_q),
    .strap_valid (strap_done)
  );

  // Own address built from three straps and two zeros
  assign addr_full = {2'b00, strap_q.station_addr};

  // Missing straps read as their pull level
  assign speed_lvl = HAS_SPEED ? strap_q.speed : `STC_DEF_SPEED;
  assign wake_lvl  = HAS_WAKE ? strap_q.wake_en : 1'b0;

  // Address compare with the broadcast-zero option
  stc_addr_match u_match (
    .pclk        (pclk),
    .presetn     (presetn),
    .own_addr    (addr_full),
    .bcast_off   (strap_q.bcast_off),
    .enable      (strap_done),
    .query_addr  (mgmt_query_addr),
    .query_valid (mgmt_query_valid),
    .hit         (mgmt_addr_hit)
  );

  // Control and advertisement images taken from the frozen straps
  always_comb begin
    strap_basic = 16'h0000;
    strap_basic[`STC_BIT_ISOLATE] = strap_q.isolate;
    strap_basic[`STC_BIT_SPEED]   = speed_lvl;
    strap_basic[`STC_BIT_DUPLEX]  = strap_q.duplex;
    strap_basic[`STC_BIT_AUTONEG] = strap_q.autoneg;
    // Ten megabit only when the speed strap was low
    if (speed_lvl) begin
      strap_adv = `STC_ADV_100_MASK | `STC_ADV_10_MASK |
                  `STC_ADV_SELECTOR;
    end else begin
      strap_adv = `STC_ADV_10_MASK | `STC_ADV_SELECTOR;
    end
  end

  // Read-only view of what was latched
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`STC_ST_ADDR_LSB +: 5] = addr_full;
    status_word[`STC_ST_MODE_LSB +: 3] = strap_q.mode;
    status_word[`STC_ST_BCAST_BIT]     = strap_q.bcast_off;
    status_word[`STC_ST_WAKE_BIT]      = wake_lvl;
    status_word[`STC_ST_NAND_BIT]      = strap_q.nand_n;
    status_word[`STC_ST_RESV_BIT]      =
      (stc_mode_decode(strap_q.mode) == STC_IF_RESV);
    status_word[`STC_ST_VALID_BIT]     = strap_done;
  end

  // APB phase decode
  assign setup_ph    = psel && !penable;
  assign access_done = psel && penable && cur_reg.pready;
  assign wr_basic    = access_done && pwrite &&
                       (paddr == `STC_BASIC_CTRL_OFF);

  // Byte lanes gate the low half; upper lanes have no storage
  always_comb begin
    wr_half = cur_reg.basic;
    if (pstrb[0]) begin
      wr_half[7:0] = pwdata[7:0];
    end
    if (pstrb[1]) begin
      wr_half[15:8] = pwdata[15:8];
    end
    // Only the four mode bits hold a value
    wr_half = wr_half & `STC_BASIC_WMASK;
  end

  // Read mux, sampled in the setup cycle
  always_comb begin
    rd_word = 32'h0000_0000;
    case (paddr)
      `STC_BASIC_CTRL_OFF: begin
        rd_word = {16'h0000, cur_reg.basic};
      end
      `STC_ADVERT_OFF: begin
        rd_word = {16'h0000, cur_reg.advert};
      end
      `STC_STRAP_STAT_OFF: begin
        rd_word = status_word;
      end
      default: begin
        rd_word = 32'h0000_0000;   // Unmapped reads zero
      end
    endcase
  end

  // Next state of the whole top
  always_comb begin
    cur_next = cur_reg;

    // Slave answers in the first access cycle, no wait states
    cur_next.pready  = setup_ph;
    cur_next.pslverr = setup_ph && !stc_addr_known(paddr);
    if (setup_ph) begin
      cur_next.prdata = pwrite ? 32'h0000_0000 : rd_word;
    end else if (access_done) begin
      cur_next.prdata = 32'h0000_0000;
    end

    // Load the images once, one edge after the strap sample
    if (strap_done && !cur_reg.loaded) begin
      cur_next.loaded = 1'b1;
      cur_next.basic  = strap_basic;
      cur_next.advert = strap_adv;
    end else if (wr_basic && cur_reg.loaded) begin
      // Software may retune after load; straps stay frozen
      cur_next.basic = wr_half;
    end

    // Mode outputs follow the control image
    cur_next.isolate_en  = cur_next.basic[`STC_BIT_ISOLATE];
    cur_next.speed_100   = cur_next.basic[`STC_BIT_SPEED];
    cur_next.duplex_half = cur_next.basic[`STC_BIT_DUPLEX];
    cur_next.autoneg_en  = cur_next.basic[`STC_BIT_AUTONEG];

    // Strap-only outputs, held until the next reset
    cur_next.station_addr = addr_full;
    cur_next.if_mode      = stc_mode_decode(strap_q.mode);
    cur_next.nand_tree_en = strap_done && !strap_q.nand_n;
    cur_next.straps_valid = strap_done && cur_reg.loaded;

    // Wake output is low-active and gated by its strap
    cur_next.wake_n = !(strap_done && wake_lvl &&
                        wake_event_req);
  end

  // Single register for the whole state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_reg.loaded       <= 1'b0;
      cur_reg.basic        <= 16'h0000;
      cur_reg.advert       <= 16'h0000;
      cur_reg.pready       <= 1'b0;
      cur_reg.pslverr      <= 1'b0;
      cur_reg.prdata       <= 32'h0000_0000;
      cur_reg.station_addr <= 5'h00;
      cur_reg.if_mode      <= STC_IF_RESV;
      cur_reg.isolate_en   <= 1'b0;
      cur_reg.speed_100    <= 1'b0;
      cur_reg.duplex_half  <= 1'b0;
      cur_reg.autoneg_en   <= 1'b0;
      cur_reg.wake_n       <= 1'b1;
      cur_reg.nand_tree_en <= 1'b0;
      cur_reg.straps_valid <= 1'b0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // Every output but mgmt_addr_hit straight from the state register; the hit comes from the u_match register
  assign prdata              = cur_reg.prdata;
  assign pready              = cur_reg.pready;
  assign pslverr             = cur_reg.pslverr;
  assign wake_event_output_n = cur_reg.wake_n;
  assign station_addr        = cur_reg.station_addr;
  assign if_mode             = cur_reg.if_mode;
  assign isolate_en          = cur_reg.isolate_en;
  assign speed_100           = cur_reg.speed_100;
  assign duplex_half         = cur_reg.duplex_half;
  assign autoneg_en          = cur_reg.autoneg_en;
  assign nand_tree_en        = cur_reg.nand_tree_en;
  assign straps_valid        = cur_reg.straps_valid;

endmodule
